/* pkg/hibernation_params.svh */
`ifndef HIBERNATION_PARAMS_SVH
`define HIBERNATION_PARAMS_SVH
// Register byte offsets
`define PWR_OFS_COUNTER   12'h000
`define PWR_OFS_MATCH0    12'h004
`define PWR_OFS_MATCH1    12'h008
`define PWR_OFS_LOAD      12'h00c
`define PWR_OFS_CONTROL   12'h010
`define PWR_OFS_MASK      12'h014
`define PWR_OFS_RAW       12'h018
`define PWR_OFS_MASKED    12'h01c
`define PWR_OFS_CLEAR     12'h020
`define PWR_OFS_TRIM      12'h024
`define PWR_OFS_DATA      12'h030
// Event bit positions in raw, mask, masked and clear registers
`define PWR_EV_MATCH0     0
`define PWR_EV_MATCH1     1
`define PWR_EV_LOW_BATTERY 2
`define PWR_EV_PIN        3
// Control register field positions
`define PWR_CTL_COUNT_EN  0
`define PWR_CTL_SLEEP     1
`define PWR_CTL_TYPE      2
`define PWR_CTL_MATCH_WK  3
`define PWR_CTL_PIN_WK    4
`define PWR_CTL_LB_EN     5
`define PWR_CTL_CLK_EN    6
`define PWR_CTL_VETO      7
`define PWR_CTL_GAP_BUSY  31
// Reset values
`define PWR_RST_WORD      32'h0000_0000
`define PWR_RST_TRIM      32'h0000_7fff
// Timing
`define PWR_XTAL_DIV      128
`define PWR_PREDIV        32768
`define PWR_CLK_NS        10
`define PWR_WRITE_GAP_NS  1000
`define PWR_WRITE_GAP_CYC ((`PWR_WRITE_GAP_NS + `PWR_CLK_NS - 1) / `PWR_CLK_NS)
`define PWR_POR_NS        160
`define PWR_POR_CYC       ((`PWR_POR_NS + `PWR_CLK_NS - 1) / `PWR_CLK_NS)
`endif

/* pkg/hibernation_pkg.sv */
package hibernation_pkg;
	// Power state, one-hot
	typedef enum logic [2:0]
	{
		ST_ACTIVE = 3'b001,
		ST_SLEEP  = 3'b010,
		ST_WAKE   = 3'b100
	} power_state_e;

	// Software control bits
	typedef struct packed
	{
		logic low_battery_veto;
		logic clock_source_enable;
		logic low_battery_detect_enable;
		logic pin_resume_enable;
		logic match_resume_enable;
		logic clock_type_select;
		logic sleep_request_bit;
		logic count_enable;
	} power_control_s;

	// Sticky event flags
	typedef struct packed
	{
		logic pin_wake;
		logic low_battery_flag;
		logic match1;
		logic match0;
	} events_s;
endpackage : hibernation_pkg

/* verilog/hibernation_power_control.sv */
// The register addresses and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "hibernation_params.svh"
`default_nettype none
module hibernation_power_control #(
	parameter int unsigned PREDIV = `PWR_PREDIV // Slow ticks per second
)(
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        slow_clock_in_i,
	output logic             crystal_drive_out_o,
	input  wire logic        resume_n_i,
	input  wire logic        battery_low_i,
	input  wire logic        regulator_off_n_i,
	output logic             regulator_off_n_o,
	output logic             regulator_off_n_oe_o,
	output logic             system_reset_o,
	output logic             irq_o
);
	hibernation_pkg::power_state_e   state;      // Power state
	hibernation_pkg::power_control_s ctl;        // Control bits
	hibernation_pkg::events_s        raw;        // Sticky events
	logic [3:0]  mask;                           // Interrupt mask
	logic [31:0] counter, match0, match1, trim, data_word;
	logic [11:0] addr_q;                         // Captured address
	logic        wr_q;                           // Write data phase
	logic        rd_q;                           // Read wait phase
	logic        s1, s2, s3;                     // Slow clock synchroniser
	logic [6:0]  xdiv;                           // Crystal divider
	logic [15:0] prediv;                         // Seconds predivider
	logic [15:0] gap_cnt;                        // Write gap timer
	logic [7:0]  por_cnt;                        // Reset pulse timer
	logic        ref_tick, sec_tick, vetoed, wake_src, go_sleep, refuse;
	logic        wr_ctl, wr_clr, hit0, hit1, wake_now;
	hibernation_pkg::events_s set_ev;

	// Timed registers sit behind the slow domain
	function automatic logic is_restricted(input logic [11:0] a);
		is_restricted = (a == `PWR_OFS_COUNTER) || (a == `PWR_OFS_MATCH0) ||
			(a == `PWR_OFS_MATCH1) || (a == `PWR_OFS_LOAD) ||
			(a == `PWR_OFS_TRIM) || (a == `PWR_OFS_DATA);
	endfunction : is_restricted

	// Slow clock synchroniser; first stage feeds only the second
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end
		else
		begin
			s1 <= slow_clock_in_i;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// Reference tick: crystal divided, oscillator direct; nothing while disabled
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			xdiv     <= 7'h00;
			ref_tick <= 1'b0;
		end
		else
		begin
			ref_tick <= 1'b0;
			if (ctl.clock_source_enable && s2 && !s3)
			begin
				xdiv <= xdiv + 7'h01;
				// Zero picks the divided crystal, one the oscillator
				ref_tick <= ctl.clock_type_select ||
					(xdiv == 7'(`PWR_XTAL_DIV - 1));
			end
		end
	end

	// Predivider to one tick per second; trim word held but not applied
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			prediv   <= 16'h0000;
			sec_tick <= 1'b0;
		end
		else
		begin
			sec_tick <= 1'b0;
			if (ref_tick)
			begin
				if (prediv == 16'(PREDIV - 1))
				begin
					prediv   <= 16'h0000;
					sec_tick <= ctl.count_enable;
				end
				else
				begin
					prediv <= prediv + 16'h0001;
				end
			end
		end
	end

	assign hit0     = sec_tick && (counter + 32'h1 == match0);
	assign hit1     = sec_tick && (counter + 32'h1 == match1);
	assign vetoed   = ctl.low_battery_veto && raw.low_battery_flag;
	assign wake_src = ctl.pin_resume_enable || ctl.match_resume_enable;
	assign go_sleep = (state == hibernation_pkg::ST_ACTIVE) &&
		ctl.sleep_request_bit && wake_src && !vetoed;
	assign refuse   = (state == hibernation_pkg::ST_ACTIVE) &&
		ctl.sleep_request_bit && !(wake_src && !vetoed);
	assign wake_now = (state == hibernation_pkg::ST_SLEEP) &&
		((ctl.pin_resume_enable && !resume_n_i) ||
		(ctl.match_resume_enable && (hit0 || hit1)));
	assign wr_ctl   = wr_q && (addr_q == `PWR_OFS_CONTROL);
	assign wr_clr   = wr_q && (addr_q == `PWR_OFS_CLEAR);

	// Event sources feeding the sticky flags
	always_comb
	begin
		set_ev.match0 = hit0;
		set_ev.match1 = hit1;
		set_ev.pin_wake = ctl.pin_resume_enable && !resume_n_i;
		// Monitor frozen while in hibernation
		set_ev.low_battery_flag = ctl.low_battery_detect_enable && battery_low_i &&
			(state != hibernation_pkg::ST_SLEEP);
	end

	// Bus slave: writes land in the data phase, reads take one wait state
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			addr_q    <= 12'h000;
			wr_q      <= 1'b0;
			rd_q      <= 1'b0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= `PWR_RST_WORD;
		end
		else
		begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			hreadyout <= 1'b1;
			if (rd_q)
			begin
				// Unmapped offsets read zero; back-to-back reads are fine
				unique case (addr_q)
					`PWR_OFS_COUNTER: hrdata <= counter;
					`PWR_OFS_MATCH0:  hrdata <= match0;
					`PWR_OFS_MATCH1:  hrdata <= match1;
					`PWR_OFS_CONTROL: hrdata <= {(gap_cnt != 16'h0000), 23'h0, ctl};
					`PWR_OFS_MASK:    hrdata <= {28'h0, mask};
					`PWR_OFS_RAW:     hrdata <= {28'h0, raw};
					`PWR_OFS_MASKED:  hrdata <= {28'h0, raw & mask};
					`PWR_OFS_TRIM:    hrdata <= trim;
					`PWR_OFS_DATA:    hrdata <= data_word;
					default:          hrdata <= `PWR_RST_WORD;
				endcase
			end
			else if (hsel && hready && htrans[1])
			begin
				addr_q <= {haddr[11:2], 2'b00};
				wr_q   <= hwrite;
				rd_q   <= !hwrite;
				// Stall reads one cycle so hrdata can be loaded from the register
				hreadyout <= hwrite;
			end
		end
	end

	// Software control bits; sleep bit clears on refusal or on wake
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			ctl <= '0;
		end
		else
		begin
			if (wr_ctl)
			begin
				ctl <= hwdata[7:0];
			end
			else if (refuse || state == hibernation_pkg::ST_WAKE)
			begin
				ctl.sleep_request_bit <= 1'b0;
			end
		end
	end

	// Counter, matches, load, trim and retained word
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			counter   <= `PWR_RST_WORD;
			match0    <= `PWR_RST_WORD;
			match1    <= `PWR_RST_WORD;
			trim      <= `PWR_RST_TRIM;
			data_word <= `PWR_RST_WORD;
			mask      <= 4'h0;
		end
		else
		begin
			if (wr_q && addr_q == `PWR_OFS_LOAD)
				counter <= hwdata;
			else if (sec_tick)
				counter <= counter + 32'h1;
			if (wr_q && addr_q == `PWR_OFS_MATCH0)
				match0 <= hwdata;
			if (wr_q && addr_q == `PWR_OFS_MATCH1)
				match1 <= hwdata;
			if (wr_q && addr_q == `PWR_OFS_TRIM)
				trim <= hwdata;
			if (wr_q && addr_q == `PWR_OFS_DATA)
				data_word <= hwdata;
			if (wr_q && addr_q == `PWR_OFS_MASK)
				mask <= hwdata[3:0];
		end
	end

	// Gap timer after a timed write; shown as a busy bit only
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			gap_cnt <= 16'h0000;
		else if (wr_q && is_restricted(addr_q))
			gap_cnt <= 16'(`PWR_WRITE_GAP_CYC);
		else if (gap_cnt != 16'h0000)
			gap_cnt <= gap_cnt - 16'h0001;
	end

	// Sticky events: a new event wins over a clear in the same cycle
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			raw <= '0;
		else
			raw <= (raw & ~(wr_clr ? hwdata[3:0] : 4'h0)) | set_ev;
	end

	// One interrupt line for all enabled events
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(raw & mask);
	end

	// Power state machine
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			state   <= hibernation_pkg::ST_ACTIVE;
			por_cnt <= 8'h00;
		end
		else
		begin
			unique case (state)
				hibernation_pkg::ST_ACTIVE:
				begin
					if (go_sleep)
						state <= hibernation_pkg::ST_SLEEP;
				end
				hibernation_pkg::ST_SLEEP:
				begin
					if (wake_now)
					begin
						state   <= hibernation_pkg::ST_WAKE;
						por_cnt <= 8'(`PWR_POR_CYC);
					end
				end
				hibernation_pkg::ST_WAKE:
				begin
					// Hold the rest of the system in reset as after power-up
					if (por_cnt == 8'h01)
						state <= hibernation_pkg::ST_ACTIVE;
					por_cnt <= por_cnt - 8'h01;
				end
			endcase
		end
	end

	// Pins: open-drain low only while hibernating, reset pulse on wake
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			regulator_off_n_o    <= 1'b0;
			regulator_off_n_oe_o <= 1'b0;
			system_reset_o       <= 1'b0;
			crystal_drive_out_o  <= 1'b0;
		end
		else
		begin
			regulator_off_n_o    <= 1'b0;
			regulator_off_n_oe_o <= go_sleep ||
				(state == hibernation_pkg::ST_SLEEP && !wake_now);
			system_reset_o <= wake_now ||
				(state == hibernation_pkg::ST_WAKE && por_cnt != 8'h01);
			crystal_drive_out_o <= ctl.clock_source_enable && !ctl.clock_type_select;
		end
	end

	chk_regoff_in_sleep: assert property (@(posedge clk_i) disable iff (reset_i)
		regulator_off_n_oe_o == (state == hibernation_pkg::ST_SLEEP))
		else $error("regulator-off enable disagrees with state");
	chk_pin_wake: assert property (@(posedge clk_i) disable iff (reset_i)
		state == hibernation_pkg::ST_SLEEP && ctl.pin_resume_enable && !resume_n_i
		|=> state == hibernation_pkg::ST_WAKE)
		else $error("pin did not wake");
	chk_wake_release: assert property (@(posedge clk_i) disable iff (reset_i)
		state == hibernation_pkg::ST_WAKE |-> !regulator_off_n_oe_o)
		else $error("regulator-off still driven after wake");
	chk_match_wake: assert property (@(posedge clk_i) disable iff (reset_i)
		state == hibernation_pkg::ST_SLEEP && ctl.match_resume_enable && hit0
		|=> state == hibernation_pkg::ST_WAKE)
		else $error("match did not wake");
	chk_por_pulse: assert property (@(posedge clk_i) disable iff (reset_i)
		$rose(state == hibernation_pkg::ST_WAKE) |-> system_reset_o [*8])
		else $error("reset pulse too short");
	chk_veto_refuse: assert property (@(posedge clk_i) disable iff (reset_i)
		state == hibernation_pkg::ST_ACTIVE && vetoed
		|=> state == hibernation_pkg::ST_ACTIVE)
		else $error("sleep entered under low battery veto");
	chk_low_battery_flag_frozen: assert property (@(posedge clk_i) disable iff (reset_i)
		state == hibernation_pkg::ST_SLEEP && $past(state) == hibernation_pkg::ST_SLEEP
		&& !$past(wr_clr) |-> $stable(raw.low_battery_flag))
		else $error("low battery flag moved in hibernation");
	chk_irq_or: assert property (@(posedge clk_i) disable iff (reset_i)
		irq_o == |($past(raw) & $past(mask)))
		else $error("interrupt not the OR of enabled events");
	chk_crystal_div: assert property (@(posedge clk_i) disable iff (reset_i)
		ref_tick && !ctl.clock_type_select |-> $past(xdiv) == 7'h7f)
		else $error("crystal path tick off the divide count");
	chk_read_wait: assert property (@(posedge clk_i) disable iff (reset_i)
		!hreadyout |=> hreadyout)
		else $error("read stalled more than one cycle");
endmodule : hibernation_power_control
`default_nettype wire

/* bench/regulator_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Regulator, wake button and slow oscillator on the far side of the block
module regulator_model
(
	input  wire logic clk_i,        // System clock
	input  wire logic off_oe_i,     // Regulator-off driver enable
	input  wire logic off_val_i,    // Regulator-off driven value
	input  wire logic wake_i,       // Bench asks for a wake press
	output logic      pin_o,        // Resolved regulator-off wire
	output logic      resume_n_o,   // Resume pin level
	output logic      power_good_o, // Main supply present
	output logic      slow_clk_o    // Free-running slow oscillator
);
	// Oscillator runs free, slower than half the system clock
	initial
	begin
		slow_clk_o = 1'b0;
		forever #40 slow_clk_o = ~slow_clk_o;
	end

	// Pull-up wins unless the block sinks the wire
	assign pin_o = off_oe_i ? off_val_i : 1'b1;

	// Weak pull-up, pressed means low
	assign resume_n_o = wake_i ? 1'b0 : 1'b1;

	// Regulator follows its enable one cycle late; unknown until the first edge
	always_ff @(posedge clk_i)
	begin
		power_good_o <= pin_o;
	end
endmodule : regulator_model
`default_nettype wire

/* bench/hibernation_power_control_test.sv */
`timescale 1ns/1ps
`include "hibernation_params.svh"
`default_nettype none
module hibernation_power_control_test;
	logic        clk_i;       // System clock
	logic        reset_i;     // Async reset
	logic        hsel;        // Bus select
	logic [31:0] haddr;       // Bus address
	logic [1:0]  htrans;      // Bus transfer kind
	logic        hwrite;      // Bus direction
	logic [2:0]  hsize;       // Bus transfer size
	logic [31:0] hwdata;      // Bus write data
	logic [31:0] hrdata;      // Bus read data
	logic        hreadyout;   // Slave ready, also bus ready
	logic        hresp;       // Slave response
	logic        slow;        // Slow clock
	logic        xdrv;        // Crystal drive
	logic        resume_n;    // Resume pin
	logic        battery_low; // Battery monitor
	logic        pin;         // Regulator-off wire
	logic        off_val;     // Regulator-off value
	logic        oe;          // Regulator-off enable
	logic        sys_rst;     // Power-on reset out
	logic        irq;         // Interrupt
	logic        wake;        // Wake press request
	logic        pgood;       // Main supply present
	logic [31:0] rd;          // Last read word
	int          n_errors;    // Mismatches
	int          total_checks; // Comparisons
	int          n;           // Cycle count

	hibernation_power_control #(.PREDIV(4)) i_dut
	(
		.clk_i(clk_i), .reset_i(reset_i), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .slow_clock_in_i(slow),
		.crystal_drive_out_o(xdrv), .resume_n_i(resume_n), .battery_low_i(battery_low),
		.regulator_off_n_i(pin), .regulator_off_n_o(off_val), .regulator_off_n_oe_o(oe),
		.system_reset_o(sys_rst), .irq_o(irq)
	);

	regulator_model i_reg
	(
		.clk_i(clk_i), .off_oe_i(oe), .off_val_i(off_val), .wake_i(wake), .pin_o(pin),
		.resume_n_o(resume_n), .power_good_o(pgood), .slow_clk_o(slow)
	);

	// Clock generator
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// Compare and count
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// One single AHB transfer; waits on hready, the watchdog ends a hang
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clk_i);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		htrans <= 2'b10;
		hwrite <= wr;
		hsize <= 3'b010;
		do @(posedge clk_i); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge clk_i); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus

	// Read and compare
	task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask : rdchk

	// Let cycles pass, land mid-cycle
	task automatic idle(input int c);
		repeat (c) @(posedge clk_i);
		#1;
	endtask : idle

	// Bounded wait for the regulator-off enable
	task automatic wait_oe(input logic v, input int lim);
		n = 0;
		while (oe !== v && n < lim)
		begin
			@(posedge clk_i);
			#1;
			n++;
		end
		chk("oe wait", 32'(v), 32'(oe));
	endtask : wait_oe

	// Verdict, single exit
	task automatic stop_test;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test

	// Watchdog: tests take about five thousand cycles, allow over three times that
	initial
	begin
		#200us;
		n_errors++;
		stop_test();
	end

	// Main sequence
	initial
	begin
		n_errors = 0;
		total_checks = 0;
		reset_i = 1'b1;
		{hsel, hwrite, wake, battery_low} = 4'h0;
		{haddr, hwdata} = 64'h0;
		htrans = 2'b00;
		hsize = 3'b000;
		repeat (4) @(posedge clk_i);
		reset_i <= 1'b0;
		idle(2);
		chk("idle outs", 32'h0, 32'({oe, sys_rst, irq, hresp}));
		rdchk("ctl reset", `PWR_OFS_CONTROL, `PWR_RST_WORD);
		rdchk("trim reset", `PWR_OFS_TRIM, `PWR_RST_TRIM);
		rdchk("unmapped", 12'h040, 32'h0);
		// Timed register, gap kept before reading back
		bus(1'b1, `PWR_OFS_DATA, 32'h1234_5678);
		idle(`PWR_WRITE_GAP_CYC + 10);
		rdchk("data", `PWR_OFS_DATA, 32'h1234_5678);
		rdchk("data again", `PWR_OFS_DATA, 32'h1234_5678);
		// Crystal path counting: 128 slow edges of 8 cycles per tick, 4 ticks a second
		bus(1'b1, `PWR_OFS_CONTROL, 32'h41);
		idle(3);
		chk("xtal drive", 32'h1, 32'(xdrv));
		idle(2000);
		// Undivided this would have counted far past one by now
		rdchk("xtal early", `PWR_OFS_COUNTER, 32'h0);
		idle(2600);
		rdchk("xtal second", `PWR_OFS_COUNTER, 32'h1);
		bus(1'b1, `PWR_OFS_CONTROL, 32'h44);
		idle(3);
		chk("osc drive", 32'h0, 32'(xdrv));
		// Low battery flag and interrupt
		@(posedge clk_i);
		battery_low <= 1'b1;
		bus(1'b1, `PWR_OFS_CONTROL, 32'h64);
		idle(5);
		rdchk("raw battery", `PWR_OFS_RAW, 32'h4);
		bus(1'b1, `PWR_OFS_MASK, 32'h4);
		idle(3);
		chk("irq battery", 32'h1, 32'(irq));
		rdchk("masked battery", `PWR_OFS_MASKED, 32'h4);
		// Veto refuses sleep, sleep bit drops
		bus(1'b1, `PWR_OFS_CONTROL, 32'hf6);
		idle(3);
		chk("veto oe", 32'h0, 32'(oe));
		rdchk("veto ctl", `PWR_OFS_CONTROL, 32'hf4);
		// No wake source enabled, refused
		bus(1'b1, `PWR_OFS_CONTROL, 32'h66);
		idle(3);
		chk("no source oe", 32'h0, 32'(oe));
		rdchk("no source ctl", `PWR_OFS_CONTROL, 32'h64);
		// Pin wake path
		bus(1'b1, `PWR_OFS_CONTROL, 32'h76);
		idle(3);
		chk("sleep oe", 32'h1, 32'(oe));
		chk("sleep pin", 32'h0, 32'(pin));
		chk("power off", 32'h0, 32'(pgood));
		bus(1'b1, `PWR_OFS_CLEAR, 32'h4);
		idle(5);
		rdchk("raw frozen", `PWR_OFS_RAW, 32'h0);
		@(posedge clk_i);
		wake <= 1'b1;
		wait_oe(1'b0, 20);
		chk("por start", 32'h1, 32'(sys_rst));
		n = 0;
		while (sys_rst === 1'b1 && n < 100)
		begin
			@(posedge clk_i);
			#1;
			n++;
		end
		chk("por length", `PWR_POR_CYC, 32'(n));
		@(posedge clk_i);
		wake <= 1'b0;
		idle(3);
		chk("power back", 32'h1, 32'(pgood));
		rdchk("ctl woke", `PWR_OFS_CONTROL, 32'h74);
		rdchk("raw woke", `PWR_OFS_RAW, 32'hc);
		@(posedge clk_i);
		battery_low <= 1'b0;
		bus(1'b1, `PWR_OFS_CLEAR, 32'hf);
		// Match wake path, pin wake disabled
		bus(1'b1, `PWR_OFS_LOAD, 32'h0);
		idle(`PWR_WRITE_GAP_CYC + 10);
		bus(1'b1, `PWR_OFS_MATCH0, 32'h3);
		idle(`PWR_WRITE_GAP_CYC + 10);
		bus(1'b1, `PWR_OFS_CONTROL, 32'h4f);
		idle(3);
		chk("match sleep", 32'h1, 32'(oe));
		@(posedge clk_i);
		wake <= 1'b1;
		idle(6);
		chk("pin ignored", 32'h1, 32'(oe));
		@(posedge clk_i);
		wake <= 1'b0;
		wait_oe(1'b0, 1000);
		chk("match por", 32'h1, 32'(sys_rst));
		idle(30);
		stop_test();
	end
endmodule : hibernation_power_control_test
`default_nettype wire
